// [design/csfr_pkg.sv]
// csfr_pkg: constants and carriers for the core special-function registers.
// assumes one instruction clock; no bus, the core's datapath drives the ports.
package csfr_pkg;
  localparam int unsigned DW = 8;
  localparam int unsigned PCW = 12;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned FILE_AW = 5;
  localparam logic [4:0] A_INDIRECT = 5'h00;
  localparam logic [4:0] A_COUNTER = 5'h01;
  localparam logic [4:0] A_PC_LOW = 5'h02;
  localparam logic [4:0] A_FLAGS = 5'h03;
  localparam logic [4:0] A_POINTER = 5'h04;
  localparam logic [4:0] A_PORT_A = 5'h05;
  localparam logic [4:0] A_PORT_E = 5'h09;
  localparam logic [4:0] MODE_CMP_XCHG = 5'h08;
  localparam logic [4:0] MODE_WAKE_XCHG = 5'h19;
  localparam logic [4:0] MODE_DIR = 5'h1f;
  localparam logic [4:0] MODE_RESET = 5'h1f;
  localparam logic [4:0] MODE_WAKE_EDGE = 5'h1a;
  localparam logic [4:0] MODE_WAKE_EN = 5'h1b;
  localparam logic [2:0] PORT_B = 3'd1;
  localparam logic [7:0] PORT_CFG_RESET = 8'hff;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [7:0] CMP_RESET = 8'hff;
  localparam logic [7:0] WAKE_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h18;
  // flag register bit positions
  localparam int unsigned F_PAGE_HI = 7;
  localparam int unsigned F_PAGE_LO = 5;
  localparam int unsigned F_WDOG = 4;
  localparam int unsigned F_SLEEP = 3;
  localparam int unsigned F_ZERO = 2;
  localparam int unsigned F_HALF = 1;
  localparam int unsigned F_CARRY = 0;
  // option register bit positions
  localparam int unsigned O_TIMER_SEL = 7;
  localparam int unsigned O_IRQ_EN_N = 6;
  localparam int unsigned O_EXT_CLK = 5;
  localparam int unsigned O_EDGE = 4;
  localparam int unsigned O_PSA = 3;
  // comparator control bit positions
  localparam int unsigned C_EN_N = 7;
  localparam int unsigned C_OE_N = 6;
  localparam int unsigned C_RESULT = 0;

  typedef enum logic [2:0] {
    CSFR_ALU_NONE, CSFR_ALU_ADD, CSFR_ALU_SUB, CSFR_ALU_RR, CSFR_ALU_RL,
    CSFR_ALU_LOGIC
  } csfr_alu_op_t;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] wdata;
  } csfr_file_req_t;

  typedef struct packed {
    csfr_alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
  } csfr_alu_req_t;

  typedef struct packed {
    logic kick;
    logic sleep;
    logic timeout;
  } csfr_wdog_ev_t;
endpackage : csfr_pkg

// [design/csfr_regs.sv]
// csfr_regs: special-function register bank of an 8-bit core.
// assumes the core's decoder drives file, mode, alu, stack and wdog ports.
// How it works
// - mode 19h config write swaps working reg with wake flags, loading them from it
// - wake flag reads 1 after a qualifying edge, else 0
// - mode 08h config write swaps working reg with comparator control
// - comparator bit7 low enables it; bit6 low drives result to pin
// - comparator bit0 is 1 when positive input exceeds negative
// - port config registers load all ones at power-up
// - mode selector resets to 1fh, direction registers first
// - address 00h redirects through pointer low five bits, no storage
// - eight-deep twelve-bit return stack for calls and returns
// - addresses 01h-09h decode counter, pc, flags, pointer, ports a-e
// - pc low byte read/write; page bits supply top three bits
// - watchdog and sleep flag bits ignore software writes
// - flag bits 7-5 pick a 200h-word program page
// - bit4 set at power-up, kick or sleep; cleared by timeout
// - bit3 set at power-up and kick; cleared by sleep
// - zero flag follows whether the result is zero; rotates leave it unchanged
// - half carry is carry out of bit3, inverted borrow on subtract
// - carry from bit7, rotates load it, carry-in when fuse low
// - option bit7 maps 01h to working reg or counter; bit6 irq
// - option bit5 picks pin clocking; bit4 picks edge polarity
// - option bit3 assigns prescaler to counter or watchdog
// - option register resets to all ones
`timescale 1ns/1ns
module csfr_regs
  import csfr_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 5,
  parameter int unsigned NUM_GP = 22
) (
  input wire logic ref_clk, // instruction clock
  input wire logic rst_n, // async reset, active low
  input wire csfr_file_req_t file_req, // file register access
  output logic [7:0] file_rdata, // read data of file access
  input wire logic [7:0] w_reg, // working register value
  input wire logic option_we, // load option from w_reg
  input wire logic mode_we, // load mode from w_reg
  input wire logic cfg_we, // port config write (port = cfg_port)
  input wire logic [2:0] cfg_port, // 0..4 = port a..e
  output logic [7:0] xchg_rdata, // value returned to working reg
  output logic xchg_valid, // xchg_rdata applies this cycle
  input wire csfr_alu_req_t alu_req, // alu flag update
  input wire logic carry_input_fuse, // fuse bit, 0 = carry feeds alu
  output logic [7:0] alu_result, // alu result
  input wire logic pc_step, // advance pc
  input wire logic call_en, // push pc, jump
  input wire logic ret_en, // pop pc
  input wire logic [PCW-1:0] jump_target, // call destination
  output logic [PCW-1:0] pc, // full program counter
  input wire csfr_wdog_ev_t wdog_ev, // watchdog events
  input wire logic [7:0] wake_pin, // multi_input_wake pins, async
  input wire logic timer_pin, // external counter pin, async
  input wire logic comparator_pos_pin, // comparator level, async
  input wire logic comparator_neg_pin, // comparator level, async
  output logic comparator_out, // comparator_output_pin value
  output logic comparator_out_oe, // drive enable of output pin
  output logic [7:0] port_dir [NUM_PORTS], // 1 = input
  output logic [7:0] option_reg, // timer_option_control
  output logic wdog_tick, // prescaled watchdog enable
  output logic timer_irq, // counter roll-over event
  output logic [4:0] mode // mode selector
);
  logic [7:0] flags;
  logic [7:0] pointer;
  logic [7:0] counter;
  logic [7:0] wake_flags;
  logic [7:0] wake_edge_sel;
  logic [7:0] wake_en_n;
  logic [7:0] cmp_ctl;
  logic [7:0] port_data [NUM_PORTS];
  logic [7:0] gp [NUM_GP];
  logic [PCW-1:0] stack [STACK_DEPTH];
  logic [2:0] sp;
  logic [4:0] eff_addr;
  logic [7:0] wake_s1, wake_s2, wake_s3;
  logic [2:0] tpin_s;
  logic [1:0] pos_s, neg_s;
  logic [7:0] prescale;
  logic [7:0] prescale_mask;
  logic xchg_wake, xchg_cmp;
  logic [4:0] next_flags_alu;
  logic flags_alu_we;
  logic [8:0] sum;
  logic [4:0] half;
  logic cin;
  logic tick_src, counter_inc, pre_roll;

  // indirect redirect: 00h has no storage of its own
  assign eff_addr = (file_req.addr == A_INDIRECT) ? pointer[4:0]
                                                  : file_req.addr;
  assign xchg_wake = cfg_we && cfg_port == PORT_B
                     && mode == MODE_WAKE_XCHG;
  assign xchg_cmp = cfg_we && cfg_port == PORT_B
                    && mode == MODE_CMP_XCHG;
  assign xchg_valid = xchg_wake || xchg_cmp;
  assign xchg_rdata = xchg_wake ? wake_flags : cmp_ctl;

  // file read decode
  always_comb
  begin
    file_rdata = 8'h00;
    unique case (1'b1)
      eff_addr == A_INDIRECT: file_rdata = 8'h00;
      eff_addr == A_COUNTER: file_rdata =
        option_reg[O_TIMER_SEL] ? counter : w_reg;
      eff_addr == A_PC_LOW: file_rdata = pc[7:0];
      eff_addr == A_FLAGS: file_rdata = flags;
      eff_addr == A_POINTER: file_rdata = pointer;
      eff_addr >= A_PORT_A && eff_addr <= A_PORT_E:
        file_rdata = port_data[3'(eff_addr - A_PORT_A)];
      default: file_rdata = gp[5'(eff_addr - A_PORT_E - 5'd1)];
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pointer <= 8'h00;
    else if (file_req.we && eff_addr == A_POINTER)
      pointer <= file_req.wdata;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_PORTS; i++)
        port_data[i] <= 8'h00;
      for (int i = 0; i < NUM_GP; i++)
        gp[i] <= 8'h00;
    end
    else if (file_req.we && eff_addr >= A_PORT_A)
    begin
      if (eff_addr <= A_PORT_E)
        port_data[3'(eff_addr - A_PORT_A)] <= file_req.wdata;
      else
        gp[5'(eff_addr - A_PORT_E - 5'd1)] <= file_req.wdata;
    end
  end

  // mode selector and port configuration
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode <= MODE_RESET;
    else if (mode_we)
      mode <= w_reg[4:0];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_PORTS; i++)
        port_dir[i] <= PORT_CFG_RESET;
      wake_edge_sel <= PORT_CFG_RESET;
      wake_en_n <= PORT_CFG_RESET;
    end
    else if (cfg_we)
    begin
      if (mode == MODE_DIR && cfg_port < 3'(NUM_PORTS))
        port_dir[cfg_port] <= w_reg;
      else if (mode == MODE_WAKE_EDGE && cfg_port == PORT_B)
        wake_edge_sel <= w_reg;
      else if (mode == MODE_WAKE_EN && cfg_port == PORT_B)
        wake_en_n <= w_reg;
    end
  end

  // wake pins: two-stage sync then edge detect on the third stage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_s1 <= 8'h00;
      wake_s2 <= 8'h00;
      wake_s3 <= 8'h00;
    end
    else
    begin
      wake_s1 <= wake_pin;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
    end
  end

  // edge wins over the exchange load so no event is lost
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wake_flags <= WAKE_RESET;
    else
    begin
      for (int i = 0; i < DW; i++)
      begin
        if (!wake_en_n[i] && (wake_edge_sel[i] ? (wake_s3[i] && !wake_s2[i])
                                : (!wake_s3[i] && wake_s2[i])))
          wake_flags[i] <= 1'b1;
        else if (xchg_wake)
          wake_flags[i] <= w_reg[i];
      end
    end
  end

  // comparator: result bit is hardware-owned, never stored from w_reg
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_s <= 2'b00;
      neg_s <= 2'b00;
    end
    else
    begin
      pos_s <= {pos_s[0], comparator_pos_pin};
      neg_s <= {neg_s[0], comparator_neg_pin};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cmp_ctl <= CMP_RESET;
    else
    begin
      if (xchg_cmp)
        cmp_ctl[7:1] <= w_reg[7:1];
      cmp_ctl[C_RESULT] <= !cmp_ctl[C_EN_N]
                           && pos_s[1] && !neg_s[1];
    end
  end

  assign comparator_out = cmp_ctl[C_RESULT];
  assign comparator_out_oe = !cmp_ctl[C_EN_N] && !cmp_ctl[C_OE_N];

  // option register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      option_reg <= OPTION_RESET;
    else if (option_we)
      option_reg <= w_reg;
  end

  // counter clocking: pin sync is always on for the counter input
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      tpin_s <= 3'b000;
    else
      tpin_s <= {tpin_s[1:0], timer_pin};
  end

  assign tick_src = option_reg[O_EXT_CLK]
    ? (option_reg[O_EDGE] ? (tpin_s[2] && !tpin_s[1])
                          : (!tpin_s[2] && tpin_s[1]))
    : 1'b1;
  assign prescale_mask = 8'((9'h2 << option_reg[2:0]) - 9'h1);
  assign pre_roll = (prescale & prescale_mask) == prescale_mask;
  assign counter_inc = option_reg[O_PSA] ? tick_src
                                         : tick_src && pre_roll;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      prescale <= 8'h00;
    else if (option_reg[O_PSA] ? wdog_ev.kick : 1'b0)
      prescale <= 8'h00;
    else if (option_reg[O_PSA] || tick_src)
      prescale <= prescale + 8'h01;
  end

  // watchdog tick 1:1 to 1:128 when the prescaler is assigned there
  assign wdog_tick = option_reg[O_PSA]
    ? ((prescale & (prescale_mask >> 1)) == (prescale_mask >> 1))
    : 1'b1;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      counter <= 8'h00;
      timer_irq <= 1'b0;
    end
    else
    begin
      timer_irq <= 1'b0;
      if (file_req.we && eff_addr == A_COUNTER && option_reg[O_TIMER_SEL])
        counter <= file_req.wdata;
      else if (counter_inc)
      begin
        counter <= counter + 8'h01;
        timer_irq <= counter == 8'hff && !option_reg[O_IRQ_EN_N];
      end
    end
  end

  // alu flags
  assign cin = !carry_input_fuse && flags[F_CARRY];
  always_comb
  begin
    sum = 9'h000;
    half = 5'h00;
    alu_result = 8'h00;
    next_flags_alu = flags[4:0];
    flags_alu_we = 1'b1;
    unique case (alu_req.op)
      CSFR_ALU_ADD:
      begin
        sum = {1'b0, alu_req.a} + {1'b0, alu_req.b} + {8'h00, cin};
        half = {1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]} + {4'h0, cin};
        alu_result = sum[7:0];
        next_flags_alu[F_CARRY] = sum[8];
        next_flags_alu[F_HALF] = half[4];
      end
      CSFR_ALU_SUB:
      begin
        // a - b as a + ~b + carry-in; carry out is inverted borrow
        sum = {1'b0, alu_req.a} + {1'b0, ~alu_req.b}
              + {8'h00, carry_input_fuse | flags[F_CARRY]};
        half = {1'b0, alu_req.a[3:0]} + {1'b0, ~alu_req.b[3:0]}
               + {4'h0, carry_input_fuse | flags[F_CARRY]};
        alu_result = sum[7:0];
        next_flags_alu[F_CARRY] = sum[8];
        next_flags_alu[F_HALF] = half[4];
      end
      CSFR_ALU_RR:
      begin
        alu_result = {flags[F_CARRY], alu_req.a[7:1]};
        next_flags_alu[F_CARRY] = alu_req.a[0];
      end
      CSFR_ALU_RL:
      begin
        alu_result = {alu_req.a[6:0], flags[F_CARRY]};
        next_flags_alu[F_CARRY] = alu_req.a[7];
      end
      CSFR_ALU_LOGIC: alu_result = alu_req.a;
      CSFR_ALU_NONE: flags_alu_we = 1'b0;
      default: flags_alu_we = 1'b0;
    endcase
    if (alu_req.op != CSFR_ALU_RR && alu_req.op != CSFR_ALU_RL)
      next_flags_alu[F_ZERO] = alu_result == 8'h00;
  end

  // alu update lands after a software write in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      flags <= FLAGS_RESET;
    else
    begin
      if (file_req.we && eff_addr == A_FLAGS)
      begin
        flags[F_PAGE_HI:F_PAGE_LO] <= file_req.wdata[7:5];
        flags[2:0] <= file_req.wdata[2:0];
      end
      if (flags_alu_we)
        flags[2:0] <= next_flags_alu[2:0];
      if (wdog_ev.timeout)
        flags[F_WDOG] <= 1'b0;
      else if (wdog_ev.kick || wdog_ev.sleep)
        flags[F_WDOG] <= 1'b1;
      if (wdog_ev.sleep)
        flags[F_SLEEP] <= 1'b0;
      else if (wdog_ev.kick)
        flags[F_SLEEP] <= 1'b1;
    end
  end

  // program counter and return stack; bit 8 is cleared on pc-low writes
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc <= {PCW{1'b1}};
      sp <= 3'd0;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack[i] <= '0;
    end
    else if (call_en)
    begin
      stack[sp] <= pc + 12'h001;
      sp <= sp + 3'd1;
      pc <= jump_target;
    end
    else if (ret_en)
    begin
      pc <= stack[sp - 3'd1];
      sp <= sp - 3'd1;
    end
    else if (file_req.we && eff_addr == A_PC_LOW)
      pc <= {flags[F_PAGE_HI:F_PAGE_LO], 1'b0, file_req.wdata};
    else if (pc_step)
      pc <= pc + 12'h001;
  end
endmodule : csfr_regs

// [tb/csfr_regs_properties.sv]
// csfr_regs_chk: port-level properties of the special-function bank.
// assumes one clock domain; bound onto every csfr_regs instance below.
`timescale 1ns/1ns
module csfr_regs_chk
  import csfr_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 5
) (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset, active low
  input wire csfr_file_req_t file_req, // file access
  input wire logic [7:0] w_reg, // working reg
  input wire logic option_we, // option load
  input wire logic mode_we, // mode load
  input wire logic cfg_we, // config write
  input wire logic [2:0] cfg_port, // config port
  input wire logic xchg_valid, // exchange flag
  input wire logic call_en, // call
  input wire logic ret_en, // return
  input wire logic [PCW-1:0] jump_target, // call target
  input wire logic [PCW-1:0] pc, // program counter
  input wire logic comparator_out_oe, // pin enable
  input wire logic [7:0] port_dir [NUM_PORTS], // directions
  input wire logic [7:0] option_reg, // option
  input wire logic wdog_tick, // watchdog enable
  input wire logic timer_irq, // roll-over
  input wire logic [4:0] mode // mode selector
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_cmp_xchg;
    cfg_we && cfg_port == 3'd1 && mode == MODE_CMP_XCHG;
  endsequence
  property p_xchg_valid;
    xchg_valid == (cfg_we && cfg_port == 3'd1 &&
      (mode == MODE_WAKE_XCHG || mode == MODE_CMP_XCHG));
  endproperty
  property p_cmp_on;
    s_cmp_xchg ##0 w_reg[7:6] == 2'b00 |=> comparator_out_oe;
  endproperty
  property p_cmp_off;
    s_cmp_xchg ##0 w_reg[6] |=> !comparator_out_oe;
  endproperty
  property p_opt_load;
    option_we |=> option_reg == $past(w_reg);
  endproperty
  property p_mode_load;
    mode_we |=> mode == $past(w_reg[4:0]);
  endproperty
  property p_opt_reset;
    $rose(rst_n) |-> option_reg == 8'hff && mode == 5'h1f;
  endproperty
  property p_dir_reset;
    $rose(rst_n) |-> port_dir[0] == 8'hff && port_dir[NUM_PORTS-1] == 8'hff;
  endproperty
  property p_dir_write;
    cfg_we && mode == 5'h1f && cfg_port == 3'd0 |=>
      port_dir[0] == $past(w_reg);
  endproperty
  property p_call;
    call_en && !ret_en |=> pc == $past(jump_target);
  endproperty
  property p_pc_low;
    file_req.we && file_req.addr == 5'h02 && !call_en && !ret_en |=>
      pc[8:0] == {1'b0, $past(file_req.wdata)};
  endproperty
  property p_irq_pulse;
    timer_irq |=> !timer_irq;
  endproperty
  property p_wdog_tick;
    !option_reg[3] |-> wdog_tick;
  endproperty
  a_xchg_valid: assert property (p_xchg_valid)
    else $error("exchange flag wrong");
  a_cmp_on: assert property (p_cmp_on)
    else $error("comparator pin not driven");
  a_cmp_off: assert property (p_cmp_off)
    else $error("comparator pin driven");
  a_opt_load: assert property (p_opt_load)
    else $error("option load wrong");
  a_mode_load: assert property (p_mode_load)
    else $error("mode load wrong");
  a_opt_reset: assert property (p_opt_reset)
    else $error("option or mode reset wrong");
  a_dir_reset: assert property (p_dir_reset)
    else $error("direction reset wrong");
  a_dir_write: assert property (p_dir_write)
    else $error("direction write wrong");
  a_call: assert property (p_call)
    else $error("call target wrong");
  a_pc_low: assert property (p_pc_low)
    else $error("pc low write wrong");
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("roll-over pulse too long");
  a_wdog_tick: assert property (p_wdog_tick)
    else $error("watchdog tick gated");
endmodule : csfr_regs_chk
bind csfr_regs csfr_regs_chk #(.NUM_PORTS(NUM_PORTS)) u_csfr_regs_chk (
  .ref_clk, .rst_n, .file_req, .w_reg, .option_we, .mode_we, .cfg_we,
  .cfg_port, .xchg_valid, .call_en, .ret_en, .jump_target, .pc,
  .comparator_out_oe, .port_dir, .option_reg, .wdog_tick, .timer_irq, .mode
);

// [tb/csfr_regs_tb_top.sv]
// csfr_regs_tb_top: self-checking bench for the special-function bank.
// assumes the bank alone; bench plays the core's decoder and pins.
`timescale 1ns/1ns
module csfr_regs_tb_top;
  import csfr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  csfr_file_req_t file_req = '0;
  csfr_alu_req_t alu_req = '0;
  csfr_wdog_ev_t wdog_ev = '0;
  logic [7:0] file_rdata, xchg_rdata, alu_result, option_reg;
  logic [7:0] w_reg = 8'h00, wake_pin = 8'hff;
  logic option_we = 1'b0, mode_we = 1'b0, cfg_we = 1'b0;
  logic [2:0] cfg_port = 3'd0;
  logic carry_input_fuse = 1'b1, call_en = 1'b0, ret_en = 1'b0;
  logic timer_pin = 1'b0;
  logic [PCW-1:0] jump_target = 12'h000, pc;
  logic pos_pin = 1'b0, xchg_valid, cmp_out, cmp_oe, wdog_tick, timer_irq;
  logic [7:0] port_dir [5];
  logic [4:0] mode;
  int mismatches = 0;
  int samples_checked = 0;
  csfr_regs u_csfr_regs (
    .ref_clk(ref_clk), .rst_n(rst_n), .file_req(file_req),
    .file_rdata(file_rdata), .w_reg(w_reg), .option_we(option_we),
    .mode_we(mode_we), .cfg_we(cfg_we), .cfg_port(cfg_port),
    .xchg_rdata(xchg_rdata), .xchg_valid(xchg_valid), .alu_req(alu_req),
    .carry_input_fuse(carry_input_fuse), .alu_result(alu_result),
    .pc_step(1'b0), .call_en(call_en), .ret_en(ret_en),
    .jump_target(jump_target), .pc(pc), .wdog_ev(wdog_ev),
    .wake_pin(wake_pin), .timer_pin(timer_pin), .comparator_pos_pin(pos_pin),
    .comparator_neg_pin(1'b0), .comparator_out(cmp_out),
    .comparator_out_oe(cmp_oe), .port_dir(port_dir),
    .option_reg(option_reg), .wdog_tick(wdog_tick), .timer_irq(timer_irq),
    .mode(mode)
  );
  always #5 ref_clk = ~ref_clk;
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic cmp(input string what, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    file_req <= '{we: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    file_req.we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    file_req <= '{we: 1'b0, addr: a, wdata: 8'h00};
    #1 d = file_rdata;
  endtask : rd
  task automatic ld(input logic opt, input logic [7:0] w);
    @(posedge ref_clk);
    w_reg <= w;
    option_we <= opt;
    mode_we <= !opt;
    @(posedge ref_clk);
    option_we <= 1'b0;
    mode_we <= 1'b0;
  endtask : ld
  task automatic cfg(input logic [2:0] p, input logic [7:0] w,
                     output logic [7:0] x);
    @(posedge ref_clk);
    cfg_port <= p;
    w_reg <= w;
    cfg_we <= 1'b1;
    #1 x = xchg_rdata;
    @(posedge ref_clk);
    cfg_we <= 1'b0;
  endtask : cfg
  task automatic alu(input csfr_alu_op_t op, input logic [7:0] a, b);
    @(posedge ref_clk);
    alu_req <= '{op: op, a: a, b: b};
    @(posedge ref_clk);
    alu_req.op <= CSFR_ALU_NONE;
  endtask : alu
  task automatic wait_irq(output int n);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1 n++;
    end while (timer_irq !== 1'b1 && n < 2000);
    if (n >= 2000)
    begin
      mismatches++;
      $display("[ERR] timer_irq expected 1 seen 0");
      close_out();
    end
  endtask : wait_irq
  task automatic t_reset;
    logic [7:0] v;
    cmp("option", 8'hff, option_reg);
    cmp("mode", 8'h1f, {3'h0, mode});
    foreach (port_dir[i]) cmp("dir", 8'hff, port_dir[i]);
    rd(A_FLAGS, v);
    cmp("flags", 8'h18, v & 8'h18);
    cfg(3'd0, 8'h3c, v);
    @(posedge ref_clk);
    cmp("dir_a", 8'h3c, port_dir[0]);
    cmp("dir_e", 8'hff, port_dir[4]);
  endtask : t_reset
  task automatic t_wake;
    logic [7:0] v;
    // bits 7:6 sense falling edges, the rest rising
    ld(1'b0, 8'h1a);
    cfg(3'd1, 8'hc0, v);
    ld(1'b0, 8'h1b);
    cfg(3'd1, 8'h00, v);
    ld(1'b0, 8'h19);
    cfg(3'd1, 8'h00, v);
    wake_pin <= 8'h0f;
    repeat (5) @(posedge ref_clk);
    wake_pin <= 8'hff;
    repeat (5) @(posedge ref_clk);
    wake_pin <= 8'h0f;
    repeat (5) @(posedge ref_clk);
    cfg(3'd1, 8'h00, v);
    cmp("wake_pend", 8'hf0, v);
    cfg(3'd1, 8'h00, v);
    cmp("wake_clr", 8'h00, v);
  endtask : t_wake
  task automatic t_cmp;
    logic [7:0] v;
    ld(1'b0, 8'h08);
    cfg(3'd1, 8'h00, v);
    // bits 7:1 reset high; result bit stays low while bit7 disables the comparator
    cmp("cmp_old", 8'hfe, v);
    pos_pin <= 1'b1;
    repeat (5) @(posedge ref_clk);
    cfg(3'd1, 8'h00, v);
    cmp("cmp_hi", 8'h01, v);
    cmp("cmp_pin", 8'h01, {7'h0, cmp_out});
    cmp("cmp_oe", 8'h01, {7'h0, cmp_oe});
    pos_pin <= 1'b0;
    repeat (5) @(posedge ref_clk);
    cfg(3'd1, 8'h40, v);
    cmp("cmp_lo", 8'h00, v);
    @(posedge ref_clk);
    cmp("cmp_oe_off", 8'h00, {7'h0, cmp_oe});
  endtask : t_cmp
  task automatic t_flags;
    csfr_wdog_ev_t ev [4] = '{3'b001, 3'b100, 3'b010, 3'b100};
    logic [7:0] ex [4] = '{8'h08, 8'h18, 8'h10, 8'h18};
    logic [7:0] v;
    wr(A_FLAGS, 8'h00);
    rd(A_FLAGS, v);
    cmp("flags_ro", 8'h18, v);
    foreach (ev[i])
    begin
      @(posedge ref_clk);
      wdog_ev <= ev[i];
      @(posedge ref_clk);
      wdog_ev <= '0;
      rd(A_FLAGS, v);
      cmp("flags_wdog", ex[i], v);
    end
  endtask : t_flags
  task automatic t_alu;
    logic [7:0] v;
    alu(CSFR_ALU_ADD, 8'h0f, 8'h01);
    rd(A_FLAGS, v);
    cmp("add_dc", 8'h1a, v);
    alu(CSFR_ALU_ADD, 8'hff, 8'h01);
    rd(A_FLAGS, v);
    cmp("add_zc", 8'h1f, v);
    alu(CSFR_ALU_RR, 8'h02, 8'h00);
    rd(A_FLAGS, v);
    cmp("rr_c", 8'h00, v & 8'h01);
    alu(CSFR_ALU_RL, 8'h80, 8'h00);
    rd(A_FLAGS, v);
    cmp("rl_c", 8'h01, v & 8'h01);
    carry_input_fuse <= 1'b0;
    @(posedge ref_clk);
    alu_req <= '{op: CSFR_ALU_ADD, a: 8'h01, b: 8'h01};
    #1 cmp("add_cin", 8'h03, alu_result);
    @(posedge ref_clk);
    alu_req.op <= CSFR_ALU_NONE;
    carry_input_fuse <= 1'b1;
    alu(CSFR_ALU_LOGIC, 8'h00, 8'h00);
    rd(A_FLAGS, v);
    cmp("logic_z", 8'h04, v & 8'h04);
    alu(CSFR_ALU_SUB, 8'h10, 8'h01);
    rd(A_FLAGS, v);
    cmp("sub_dc", 8'h19, v);
  endtask : t_alu
  task automatic t_pc;
    for (int i = 0; i < 2; i++)
    begin
      wr(A_FLAGS, i ? 8'he0 : 8'h00);
      wr(A_PC_LOW, 8'h34);
      @(posedge ref_clk);
      cmp("pc_lo", 8'h34, pc[7:0]);
      cmp("pc_hi", i ? 8'h0e : 8'h00, {4'h0, pc[11:8]});
    end
    @(posedge ref_clk);
    jump_target <= 12'h5a5;
    call_en <= 1'b1;
    @(posedge ref_clk);
    call_en <= 1'b0;
    ret_en <= 1'b1;
    @(posedge ref_clk);
    ret_en <= 1'b0;
    @(posedge ref_clk);
    cmp("ret_hi", 8'h0e, {4'h0, pc[11:8]});
    cmp("ret_lo", 8'h35, pc[7:0]);
  endtask : t_pc
  task automatic t_ind;
    logic [7:0] v;
    wr(A_POINTER, 8'h0a);
    wr(A_INDIRECT, 8'h5a);
    rd(5'h0a, v);
    cmp("ind_wr", 8'h5a, v);
    rd(A_POINTER, v);
    cmp("pointer", 8'h0a, v);
    wr(A_POINTER, 8'h0b);
    wr(5'h0b, 8'hc3);
    rd(A_INDIRECT, v);
    cmp("ind_rd", 8'hc3, v);
  endtask : t_ind
  task automatic t_opt;
    logic [7:0] v;
    int n;
    ld(1'b1, 8'h08);
    @(posedge ref_clk);
    w_reg <= 8'ha5;
    rd(A_COUNTER, v);
    cmp("w_map", 8'ha5, v);
    wait_irq(n);
    wait_irq(n);
    cmp("gap_1to1", 8'h80, 8'(n >> 1));
    ld(1'b1, 8'h80);
    wait_irq(n);
    wait_irq(n);
    cmp("gap_1to2", 8'h80, 8'(n >> 2));
    // falling edges on the counter pin only; internal ticks must stop
    ld(1'b1, 8'hb8);
    wr(A_COUNTER, 8'h00);
    repeat (3)
    begin
      timer_pin <= ~timer_pin;
      repeat (4) @(posedge ref_clk);
    end
    rd(A_COUNTER, v);
    cmp("pin_fall", 8'h01, v);
  endtask : t_opt
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_wake();
    t_cmp();
    t_flags();
    t_alu();
    t_pc();
    t_ind();
    t_opt();
    close_out();
  end
endmodule : csfr_regs_tb_top
